/* inc/nv_ctrl_pkg.sv */
// Constants and types shared by the data EEPROM access controller
package nv_ctrl_pkg;

  // ****************************************
  // Clock and programming time
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_US  = 4000;
  localparam int PROG_CYCLES   = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ARRAY_ADDR_W = 10;
  localparam int ARRAY_DEPTH  = 1024;
  localparam int HIGH_BITS    = 2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFS_DATA      = 8'h08;
  localparam logic [7:0] OFS_UNLOCK    = 8'h0c;
  localparam logic [7:0] OFS_CONTROL   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_FLASH_BIT  = 7;
  localparam int CTL_CONFIG_BIT = 6;
  localparam int CTL_PERMIT_BIT = 2;
  localparam int CTL_WSTART_BIT = 1;
  localparam int CTL_RSTART_BIT = 0;
  localparam int DONE_BIT       = 0;

  // ****************************************
  // Unlock keys, reset values, responses
  // ****************************************
  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'haa;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_FIRST,
    LOCK_ARMED
  } lock_state_t;

  typedef struct packed {
    logic flashSpacePick;
    logic configSpacePick;
    logic programPermit;
  } ctl_t;

endpackage

/* verilog/nv_reset_sync.sv */
// Two-stage release synchroniser for the asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module nv_reset_sync (
  input  wire logic core_clk,
  input  wire logic rawReset_n,
  output var  logic syncReset_n
);

  logic stage1;

  always_ff @(posedge core_clk or negedge rawReset_n) begin
    if (!rawReset_n) begin
      stage1      <= 1'b0;
      syncReset_n <= 1'b0;
    end else begin
      stage1      <= 1'b1;
      syncReset_n <= stage1;
    end
  end

endmodule
`default_nettype wire

/* verilog/data_eeprom_access_ctrl.sv */
// Data EEPROM access controller with an AXI4-Lite register slave
//
// Contract
// R1: Read needs address loaded, flash pick cleared, then read start bit set.
// R2: Read start places the addressed byte in the data register next cycle.
// R3: Data register keeps the byte until another read or a software write.
// R4: Software loads address pair and data byte before starting a write.
// R5: Write starts only after keys 55h then 0AAh, then start bit.
// R6: Write start bit cannot be set unless the permit bit is already set.
// R7: Permit bit changes only by software write or reset, never by hardware.
// R8: Setting permit and write start in one write starts nothing.
// R9: During a write, control, address pair and data writes are ignored.
// R10: Completion clears the write start bit and sets the done flag.
// R11: Done flag stays set until software clears it.
// R12: Software should disable interrupts across the unlock and start writes.
// R13: Software should keep permit cleared except while updating the array.
// R14: Software may read back each programmed byte to verify it.
// R15: Array address is two high-register bits joined with the low register.
// R16: Write cycle is self-timed; start bit stays set for the programming time.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_ctrl
  import nv_ctrl_pkg::*;
#(
  parameter int PROG_LEN = PROG_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic        irq
);

  localparam int CNT_W = $clog2(PROG_LEN + 1);

  // ****************************************
  // Reset release
  // ****************************************
  logic rstN;
  nv_reset_sync resetSync (
    .core_clk    (core_clk),
    .rawReset_n  (reset_n),
    .syncReset_n (rstN)
  );

  // ****************************************
  // State declarations
  // ****************************************
  logic [7:0]        awAddr_q;
  logic [7:0]        wData_q;
  logic              wLane_q;
  logic              awHeld_q;
  logic              wHeld_q;
  logic [HIGH_BITS-1:0] addrHigh_q;
  logic [7:0]        addrLow_q;
  logic [7:0]        data_q;
  ctl_t              ctl_q;
  logic              busy_q;
  logic [CNT_W-1:0]  progCnt_q;
  lock_state_t       lock_q;
  logic              done_q;
  logic              mask_q;
  logic [7:0]        array [ARRAY_DEPTH];
  // ****************************************
  // Write channel join
  // ****************************************
  logic        awFire;
  logic        wFire;
  logic        aHave;
  logic        dHave;
  logic        doWrite;
  logic [7:0]  wrAddr;
  logic [7:0]  wrByte;
  logic        wrLane;
  logic        awHeldD;
  logic        wHeldD;
  logic        bvalidD;
  logic        arFire;
  logic        rvalidD;
  assign awFire  = awvalid && awready;
  assign wFire   = wvalid && wready;
  assign aHave   = awHeld_q || awFire;
  assign dHave   = wHeld_q || wFire;
  assign doWrite = aHave && dHave;
  assign wrAddr  = awHeld_q ? awAddr_q : awaddr;
  assign wrByte  = wHeld_q ? wData_q : wdata[7:0];
  assign wrLane  = wHeld_q ? wLane_q : wstrb[0];
  assign awHeldD = aHave && !doWrite;
  assign wHeldD  = dHave && !doWrite;
  assign bvalidD = (bvalid && !bready) || doWrite;
  assign arFire  = arvalid && arready;
  assign rvalidD = (rvalid && !rready) || arFire;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      awAddr_q <= RST_BYTE;
      wData_q  <= RST_BYTE;
      wLane_q  <= 1'b0;
    end else begin
      awHeld_q <= awHeldD;
      wHeld_q  <= wHeldD;
      awready  <= !awHeldD && !bvalidD;
      wready   <= !wHeldD && !bvalidD;
      bvalid   <= bvalidD;
      if (awFire) begin
        awAddr_q <= awaddr;
      end
      if (wFire) begin
        wData_q <= wdata[7:0];
        wLane_q <= wstrb[0];
      end
    end
  end

  // ****************************************
  // Register write decode
  // ****************************************
  logic mapped;
  logic program_permit;
  logic hitHigh;
  logic hitLow;
  logic hitData;
  logic hitKey;
  logic hitCtl;
  logic hitStat;
  logic hitMask;
  logic ctlRead;
  logic ctlStart;
  logic progEnd;
  logic [ARRAY_ADDR_W-1:0] arrayAddr;
  logic [7:0]  arrayOut;
  assign program_permit    = doWrite && wrLane;
  assign hitHigh = program_permit && (wrAddr == OFS_ADDR_HIGH) && !busy_q; // R9
  assign hitLow  = program_permit && (wrAddr == OFS_ADDR_LOW) && !busy_q; // R9
  assign hitData = program_permit && (wrAddr == OFS_DATA) && !busy_q; // R9
  assign hitKey  = program_permit && (wrAddr == OFS_UNLOCK) && !busy_q;
  assign hitCtl  = program_permit && (wrAddr == OFS_CONTROL) && !busy_q; // R9
  assign hitStat = program_permit && (wrAddr == OFS_IRQ_STAT);
  assign hitMask = program_permit && (wrAddr == OFS_IRQ_MASK);
  assign mapped  = (wrAddr == OFS_ADDR_HIGH) || (wrAddr == OFS_ADDR_LOW)
                || (wrAddr == OFS_DATA) || (wrAddr == OFS_UNLOCK)
                || (wrAddr == OFS_CONTROL) || (wrAddr == OFS_IRQ_STAT)
                || (wrAddr == OFS_IRQ_MASK);
  // Read only from data space, never from the flash or config space
  assign ctlRead  = hitCtl && wrByte[CTL_RSTART_BIT]
                 && !wrByte[CTL_FLASH_BIT] && !wrByte[CTL_CONFIG_BIT]; // R1
  // Permit must already be set; the written permit bit is not looked at
  assign ctlStart = hitCtl && wrByte[CTL_WSTART_BIT] && ctl_q.programPermit
                 && (lock_q == LOCK_ARMED); // R5 R6 R8
  assign progEnd  = busy_q && (progCnt_q == '0);
  assign arrayAddr = {addrHigh_q, addrLow_q}; // R15
  assign arrayOut  = array[arrayAddr];
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bresp <= mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ****************************************
  // Address pair and data register
  // ****************************************
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      addrHigh_q <= '0;
      addrLow_q  <= RST_BYTE;
    end else begin
      if (hitHigh) begin
        addrHigh_q <= wrByte[HIGH_BITS-1:0];
      end
      if (hitLow) begin
        addrLow_q <= wrByte;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      data_q <= RST_BYTE;
    end else if (ctlRead) begin
      data_q <= arrayOut; // R2
    end else if (hitData) begin
      data_q <= wrByte; // R3
    end
  end

  // ****************************************
  // Control register and unlock sequence
  // ****************************************
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ctl_q <= '0;
    end else if (hitCtl) begin
      ctl_q.flashSpacePick  <= wrByte[CTL_FLASH_BIT];
      ctl_q.configSpacePick <= wrByte[CTL_CONFIG_BIT];
      ctl_q.programPermit   <= wrByte[CTL_PERMIT_BIT]; // R7
    end
  end
  // Any write other than the next expected key drops the sequence
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      lock_q <= LOCK_IDLE;
    end else if (doWrite && !busy_q) begin
      unique case (lock_q)
        LOCK_IDLE: begin
          lock_q <= (hitKey && wrByte == KEY_FIRST) ? LOCK_FIRST : LOCK_IDLE; // R5
        end
        LOCK_FIRST: begin
          lock_q <= (hitKey && wrByte == KEY_SECOND) ? LOCK_ARMED : LOCK_IDLE; // R5
        end
        LOCK_ARMED: begin
          lock_q <= LOCK_IDLE; // R5
        end
        default: begin
          lock_q <= LOCK_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Self-timed programming
  // ****************************************
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      busy_q    <= 1'b0;
      progCnt_q <= '0;
    end else if (ctlStart) begin
      busy_q    <= 1'b1;
      progCnt_q <= CNT_W'(PROG_LEN - 1); // R16
    end else if (progEnd) begin
      busy_q <= 1'b0; // R10
    end else if (busy_q) begin
      progCnt_q <= progCnt_q - 1'b1; // R16
    end
  end
  always_ff @(posedge core_clk) begin
    if (progEnd) begin
      array[arrayAddr] <= data_q;
    end
  end

  // ****************************************
  // Done flag, mask and interrupt
  // ****************************************
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      done_q <= 1'b0;
    end else if (progEnd) begin
      done_q <= 1'b1; // R10
    end else if (hitStat && wrByte[DONE_BIT]) begin
      done_q <= 1'b0; // R11
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      mask_q <= 1'b0;
      irq    <= 1'b0;
    end else begin
      if (hitMask) begin
        mask_q <= wrByte[DONE_BIT];
      end
      irq <= done_q && mask_q;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [7:0] rdByte;
  logic       rdHit;
  always_comb begin
    rdByte = RST_BYTE;
    rdHit  = 1'b1;
    unique case (araddr)
      OFS_ADDR_HIGH: rdByte = {{(8 - HIGH_BITS){1'b0}}, addrHigh_q};
      OFS_ADDR_LOW:  rdByte = addrLow_q;
      OFS_DATA:      rdByte = data_q;
      OFS_UNLOCK:    rdByte = RST_BYTE;
      OFS_CONTROL:   rdByte = {ctl_q.flashSpacePick, ctl_q.configSpacePick, 3'h0,
                               ctl_q.programPermit, busy_q, 1'b0};
      OFS_IRQ_STAT:  rdByte = {7'h00, done_q};
      OFS_IRQ_MASK:  rdByte = {7'h00, mask_q};
      default:       rdHit  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalidD;
      rvalid  <= rvalidD;
      if (arFire) begin
        rdata <= {24'h000000, rdByte};
        rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Busy cycles counted apart from the countdown, so its length is checked
  logic [CNT_W-1:0] busyLen_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      busyLen_q <= '0;
    end else begin
      busyLen_q <= busy_q ? busyLen_q + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  AST_READ_SPACE: assert property ( // R1
    (hitCtl && wrByte[CTL_RSTART_BIT] && (wrByte[CTL_FLASH_BIT] || wrByte[CTL_CONFIG_BIT]))
      |=> $stable(data_q))
    else $error("read taken while flash or config space picked");
  AST_READ_FETCH: assert property (ctlRead |=> (data_q == $past(arrayOut))) // R2
    else $error("read byte not in data register next cycle");
  AST_DATA_HOLD: assert property ((!ctlRead && !hitData) |=> $stable(data_q)) // R3
    else $error("data register changed without read or write");
  AST_START_KEYS: assert property ($rose(busy_q) |-> ($past(lock_q) == LOCK_ARMED)) // R5
    else $error("write started without unlock keys");
  AST_START_PERMIT: assert property ($rose(busy_q) |-> $past(ctl_q.programPermit)) // R6
    else $error("write started without permit");
  AST_PERMIT_KEEP: assert property ($fell(ctl_q.programPermit) |-> $past(hitCtl)) // R7
    else $error("permit cleared by hardware");
  AST_SAME_WRITE: assert property ((hitCtl && !ctl_q.programPermit) |=> !$rose(busy_q)) // R8
    else $error("permit and start in one write started programming");
  AST_BUSY_FREEZE: assert property ( // R9
    (busy_q && $past(busy_q)) |-> ($stable(addrLow_q) && $stable(addrHigh_q)
      && $stable(data_q) && $stable(ctl_q)))
    else $error("register changed during programming");
  AST_DONE_SET: assert property ($fell(busy_q) |-> (done_q ##1 irq == mask_q)) // R10
    else $error("done flag or interrupt missing at completion");
  AST_DONE_STICKY: assert property ( // R11
    (done_q && !(hitStat && wrByte[DONE_BIT])) |=> done_q)
    else $error("done flag cleared without software");
  AST_PROG_LEN: assert property ($fell(busy_q) |-> (busyLen_q == CNT_W'(PROG_LEN))) // R16
    else $error("programming time differs from its length");
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module testbench
  import nv_ctrl_pkg::*;
();
  localparam int         PLEN   = 40;
  localparam int         LIMIT  = 20000;
  localparam logic [7:0] PERMIT = 8'h04;
  localparam logic [7:0] WSTART = 8'h02;
  localparam logic [7:0] RSTART = 8'h01;

  logic        core_clk;
  logic        reset_n;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cycles      = 0;

  data_eeprom_access_ctrl #(.PROG_LEN(PLEN)) data_eeprom_access_ctrl_inst (
    .core_clk(core_clk), .reset_n(reset_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq)
  );

  // ****************************************
  // Clock, timeout, reporting
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // ****************************************
  // Bus master tasks
  // ****************************************
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        got = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        got = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, 4'h1, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "write resp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    rdr(a, d, r);
    check(d, {24'h0, exp}, what);
  endtask

  task automatic unlock();
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), RST_BYTE, "reset value");
    end
    rdr(8'h1c, d, r);
    check({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
    axw(8'h1c, 8'hff, 4'h1, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    wr(OFS_ADDR_HIGH, 8'hff);
    rd(OFS_ADDR_HIGH, 8'h03, "high address bits");
    axw(OFS_ADDR_LOW, 8'h77, 4'h0, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "lane off resp");
    rd(OFS_ADDR_LOW, 8'h00, "lane off write");
  endtask

  task automatic t_guard();
    wr(OFS_CONTROL, 8'h00);
    unlock();
    wr(OFS_CONTROL, WSTART);
    rd(OFS_CONTROL, 8'h00, "start without permit");
    unlock();
    wr(OFS_CONTROL, PERMIT | WSTART);
    rd(OFS_CONTROL, PERMIT, "permit and start together");
    wr(OFS_CONTROL, PERMIT | WSTART);
    rd(OFS_CONTROL, PERMIT, "start without keys");
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_CONTROL, PERMIT | WSTART);
    rd(OFS_CONTROL, PERMIT, "keys reversed");
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_ADDR_LOW, 8'h12);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CONTROL, PERMIT | WSTART);
    rd(OFS_CONTROL, PERMIT, "keys interrupted");
    repeat (PLEN + 4) @(posedge core_clk);
    rd(OFS_IRQ_STAT, 8'h00, "no completion");
    wr(OFS_CONTROL, 8'h00);
  endtask

  task automatic t_write(input logic [9:0] a, input logic [7:0] v, input logic m);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(OFS_ADDR_HIGH, {6'h0, a[9:8]});
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_DATA, v);
    wr(OFS_CONTROL, PERMIT);
    unlock();
    wr(OFS_CONTROL, PERMIT | WSTART);
    rd(OFS_CONTROL, PERMIT | WSTART, "busy after start");
    wr(OFS_DATA, ~v);
    wr(OFS_ADDR_LOW, ~a[7:0]);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_DATA, v, "data frozen");
    rd(OFS_ADDR_LOW, a[7:0], "address frozen");
    n = 0;
    d = 32'h2;
    while (d[1] !== 1'b0 && n < 60) begin
      rdr(OFS_CONTROL, d, r);
      n++;
    end
    check(d, {24'h0, PERMIT}, "control after write");
    rd(OFS_IRQ_STAT, 8'h01, "done flag");
    check({31'h0, irq}, {31'h0, m}, "irq level");
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_CONTROL, 8'h00, "permit cleared after done");
  endtask

  task automatic t_irq();
    wr(OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h1, "irq unmasked");
    wr(OFS_IRQ_STAT, 8'h00);
    repeat (PLEN) @(posedge core_clk);
    rd(OFS_IRQ_STAT, 8'h01, "flag sticky");
    wr(OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rd(OFS_IRQ_STAT, 8'h00, "flag cleared");
  endtask

  task automatic t_read(input logic [9:0] a, input logic [7:0] v);
    wr(OFS_DATA, ~v);
    wr(OFS_ADDR_HIGH, {6'h0, a[9:8]});
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_CONTROL, 8'h81);
    rd(OFS_DATA, ~v, "read with flash pick");
    wr(OFS_CONTROL, 8'h41);
    rd(OFS_DATA, ~v, "read with config pick");
    wr(OFS_CONTROL, RSTART);
    rd(OFS_DATA, v, "read byte");
    rd(OFS_CONTROL, 8'h00, "read start clear");
    rd(OFS_DATA, v, "byte held");
    wr(OFS_DATA, 8'h3c);
    rd(OFS_DATA, 8'h3c, "software write");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_regs();
    t_guard();
    t_write(10'h3ff, 8'ha5, 1'b0);
    t_irq();
    t_write(10'h1ff, 8'h5a, 1'b1);
    t_read(10'h3ff, 8'ha5);
    t_read(10'h1ff, 8'h5a);
    close_out();
  end
endmodule
`default_nettype wire
